// ===== bench/eight_bit_pwm_waveform_unit_bench.sv
// Self-checking bench for the PWM waveform unit.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_regs.svh"
module eight_bit_pwm_waveform_unit_bench
    import pwm_pkg::*;
;
    logic        CLK = 1'b0;
    logic        rst_n, tick, awv, wv, br, arv, rr;
    logic [7:0]  aw, ar;
    logic [31:0] wd, rdat;
    logic [3:0]  ws;
    logic        awr, wrdy, bv, arr, rv, oa, oao, ob, obo, ovf;
    logic [1:0]  bresp, rresp;
    logic [65:0] exq[$];
    logic [65:0] note;
    int          n_errors = 0;
    int          compares = 0;

    always #2.5 CLK = ~CLK;

    eight_bit_pwm_waveform_unit DUT (.CLK(CLK), .RST_N(rst_n), .TIMER_TICK(tick),
        .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rr), .OUT_A(oa), .OUT_A_OVR(oao), .OUT_B(ob), .OUT_B_OVR(obo),
        .OVF_FLAG(ovf));

    // ==========================================================
    // Bus tasks and comparison.
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            n_errors++;
            $display("BAD %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        aw <= a;
        wd <= d;
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge CLK);
            if (awv && awr === 1'b1) awv <= 1'b0;
            if (wv && wrdy === 1'b1) wv <= 1'b0;
        end while (bv !== 1'b1);
        chk(32'(bresp), 32'(er));
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic [1:0] er);
        exq.push_back({er, m, e});
        ar <= a;
        arv <= 1'b1;
        do @(posedge CLK); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge CLK); while (rv !== 1'b1);
    endtask : rd

    // Compares each read answer with the oldest note.
    always @(posedge CLK) begin
        if (rv === 1'b1 && rr) begin
            note = exq.pop_front();
            chk(rdat & note[63:32], note[31:0]);
            chk(32'(rresp), 32'(note[65:64]));
        end
    end

    // Measures high time and period of one output between rising edges.
    task automatic meas(input bit b, output int hi, output int per);
        logic p;
        logic c;
        do @(posedge CLK); while ((b ? ob : oa) !== 1'b0);
        do @(posedge CLK); while ((b ? ob : oa) !== 1'b1);
        hi = 1;
        per = 0;
        p = 1'b1;
        forever begin
            @(posedge CLK);
            c = b ? ob : oa;
            per++;
            if (c === 1'b1 && p === 1'b0) break;
            hi += int'(c === 1'b1);
            p = c;
        end
    endtask : meas

    task automatic print_verdict;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    // ==========================================================
    // Scenarios.
    initial begin
        int t, c, top, hx, px;
        logic [2:0] md;
        logic [1:0] sa;
        static logic [2:0] mt [4] = '{`MODE_FAST_FIXED, `MODE_PC_FIXED,
                                      `MODE_FAST_CMPA, `MODE_PC_CMPA};
        rst_n = 1'b0;
        tick = 1'b0;
        {awv, wv, arv, aw, ar, wd, ws} = '0;
        br = 1'b1;
        rr = 1'b1;
        void'($urandom(32'hF0AE));
        repeat (16) @(posedge CLK);
        rst_n <= 1'b1;
        repeat (4) @(posedge CLK);
        rd(`REG_CTRL_ADDR, 32'hFFFFFFFF, 32'h0, `RESP_OKAY);
        rd(8'h14, 32'hFFFFFFFF, 32'h0, `RESP_SLVERR);
        wr(8'h14, 32'hFF, 4'hF, `RESP_SLVERR);
        wr(`REG_CTRL_ADDR, 32'h0F, 4'hF, `RESP_OKAY);
        wr(`REG_CTRL_ADDR, 32'hFF, 4'h0, `RESP_OKAY);
        rd(`REG_CTRL_ADDR, 32'hFFFFFFFF, 32'h07, `RESP_OKAY);
        chk({30'h0, oao, obo}, 32'h0);
        tick <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            md = mt[i];
            t = 'h80 + $urandom % 'h70;
            c = 1 + $urandom % 'h3F;
            sa = (md[1] ^ md[2]) ? `SEL_NONINV : `SEL_INV;
            top = md[2] ? t : 255;
            wr(`REG_CMPA_ADDR, 32'(t), 4'hF, `RESP_OKAY);
            wr(`REG_CMPB_ADDR, 32'(c), 4'hF, `RESP_OKAY);
            wr(`REG_CTRL_ADDR, {24'h0, sa, `SEL_NONINV, 1'b0, md}, 4'hF, `RESP_OKAY);
            repeat (600) @(posedge CLK);
            chk({30'h0, oao, obo}, {30'h0, sa != 2'h0, 1'b1});
            meas(1'b1, hx, px);
            chk(32'(px), 32'(md[1] ? top + 1 : 2 * top));
            chk(32'(hx), 32'(md[1] ? c + 1 : 2 * c));
            if (!md[2]) begin
                meas(1'b0, hx, px);
                t = md[1] ? t + 1 : 2 * t;
                chk(32'(hx), 32'(sa == `SEL_INV ? px - t : t));
            end
            tick <= 1'b0;
            rd(`REG_STATUS_ADDR, 32'h1, 32'h1, `RESP_OKAY);
            wr(`REG_STATUS_ADDR, 32'h1, 4'hF, `RESP_OKAY);
            rd(`REG_STATUS_ADDR, 32'h1, 32'h0, `RESP_OKAY);
            tick <= 1'b1;
        end
        wr(`REG_CMPA_ADDR, 32'h3, 4'hF, `RESP_OKAY);
        wr(`REG_CTRL_ADDR, {24'h0, `SEL_TOGGLE, `SEL_TOGGLE, 1'b0, `MODE_FAST_CMPA}, 4'hF,
           `RESP_OKAY);
        repeat (600) @(posedge CLK);
        chk({30'h0, oao, obo}, 32'h2);
        meas(1'b0, hx, px);
        chk(32'(px), 32'h8);
        chk(32'(hx), 32'h4);
        for (int v = 0; v < 2; v++) begin
            wr(`REG_CMPB_ADDR, v ? 32'hFF : 32'h0, 4'hF, `RESP_OKAY);
            wr(`REG_CTRL_ADDR, {24'h0, `SEL_TOGGLE, `SEL_NONINV, 1'b0, `MODE_PC_FIXED}, 4'hF,
               `RESP_OKAY);
            repeat (1100) @(posedge CLK);
            chk(32'(oao), 32'h0);
            hx = 0;
            repeat (520) begin
                @(posedge CLK);
                hx += int'(ob === 1'b1);
            end
            chk(32'(hx), v ? 32'h208 : 32'h0);
        end
        print_verdict();
    end

    initial begin
        #400000;
        n_errors++;
        print_verdict();
    end
endmodule : eight_bit_pwm_waveform_unit_bench
`default_nettype wire

// ===== shared/pwm_pkg.sv
// Types shared by the PWM waveform unit and its register bus slave.
package pwm_pkg;

    typedef struct packed {
        logic [1:0] sel_a;
        logic [1:0] sel_b;
        logic       rsvd;
        logic [2:0] mode;
    } ctrl_t;

    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_wr_t;

    typedef enum logic {
        DIR_UP   = 1'b0,
        DIR_DOWN = 1'b1
    } dir_t;

endpackage : pwm_pkg

// ===== shared/pwm_regs.svh
// Offsets, field codes, reset values and timing counts of the PWM waveform unit.
`ifndef PWM_REGS_SVH
`define PWM_REGS_SVH

`define AXI_AW            8
`define REG_CTRL_ADDR     8'h00
`define REG_CMPA_ADDR     8'h04
`define REG_CMPB_ADDR     8'h08
`define REG_COUNT_ADDR    8'h0C
`define REG_STATUS_ADDR   8'h10

`define CTRL_RESET        8'h00
`define CMP_RESET         8'h00
`define STATUS_OVF_BIT    0

`define MODE_PC_FIXED     3'h1
`define MODE_FAST_FIXED   3'h3
`define MODE_PC_CMPA      3'h5
`define MODE_FAST_CMPA    3'h7

`define SEL_OFF           2'h0
`define SEL_TOGGLE        2'h1
`define SEL_NONINV        2'h2
`define SEL_INV           2'h3

`define TOP_FIXED         8'hFF
`define BOTTOM            8'h00

`define FAST_PERIOD       10'h100
`define DUAL_PERIOD       10'h1FE

`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ===== verilog/eight_bit_pwm_waveform_unit.sv
// Single-slope and dual-slope PWM waveform unit for an eight-bit timer/counter.
// Behaviour
// (RULE1) Mode 3 or 7 runs the counter single-slope, bottom to top, then bottom.
// (RULE2) Single-slope top is 0xFF in mode 3, compare A in mode 7.
// (RULE3) Single-slope counter at top clears to zero on the next timer tick.
// (RULE4) Single-slope non-inverting: clear on compare match, set on wrap to bottom.
// (RULE5) Single-slope inverting: set on compare match, clear on wrap to bottom.
// (RULE6) Single-slope overflow flag sets each time the counter reaches top.
// (RULE7) Selection 1 toggles channel A on match only with mode msb set; B never.
// (RULE8) Single-slope toggle gives 50% duty, up to half the clock at compare zero.
// (RULE9) Compare A bottom gives a one-tick spike; MAX gives a constant level.
// (RULE10) Single-slope with top 0xFF repeats every 256 timer ticks.
// (RULE11) Compare double buffering is active in both PWM families.
// (RULE12) Mode 1 or 5 runs the counter dual-slope, up to top and back down.
// (RULE13) Dual-slope top is 0xFF in mode 1, compare A in mode 5.
// (RULE14) Dual-slope reverses at top and holds top for exactly one tick.
// (RULE15) Dual-slope non-inverting clears on up match, sets on down match; inverse.
// (RULE16) Dual-slope overflow flag sets each time the counter reaches bottom.
// (RULE17) Dual-slope with top 0xFF repeats every 510 timer ticks.
// (RULE18) Dual-slope compare bottom holds low, MAX holds high; inverted is opposite.
// (RULE19) Selection 0 disconnects the channel and leaves the pin to the port.
// (RULE20) Software sets the pin direction to output; the unit never drives it.
// (RULE21) Buffered compare values load into the active ones when the counter is at top.
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_regs.svh"

module eight_bit_pwm_waveform_unit
    import pwm_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        TIMER_TICK,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    output logic             OUT_A,
    output logic             OUT_A_OVR,
    output logic             OUT_B,
    output logic             OUT_B_OVR,
    output logic             OVF_FLAG
);

    // ======================================================================
    // Reset release.
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // ======================================================================
    // Helper functions.
    function automatic logic is_fast(input logic [2:0] m);
        is_fast = (m == `MODE_FAST_FIXED) || (m == `MODE_FAST_CMPA);
    endfunction : is_fast

    function automatic logic is_dual(input logic [2:0] m);
        is_dual = (m == `MODE_PC_FIXED) || (m == `MODE_PC_CMPA);
    endfunction : is_dual

    function automatic logic drives(input logic [1:0] sel, input logic tog_ok);
        drives = (sel == `SEL_NONINV) || (sel == `SEL_INV) ||
                 ((sel == `SEL_TOGGLE) && tog_ok);
    endfunction : drives

    function automatic logic wave_next(
        input logic       pin,
        input logic [1:0] sel,
        input logic       tog_ok,
        input logic       fast,
        input logic       match,
        input logic       wrap,
        input logic       down
    );
        wave_next = pin;
        unique case (sel)
            `SEL_OFF: begin
                wave_next = pin;
            end
            `SEL_TOGGLE: begin
                if (tog_ok && match) begin
                    wave_next = ~pin;
                end
            end
            `SEL_NONINV: begin
                if (fast) begin
                    wave_next = wrap ? 1'b1 : (match ? 1'b0 : pin);
                end else if (match) begin
                    wave_next = down;
                end
            end
            `SEL_INV: begin
                if (fast) begin
                    wave_next = wrap ? 1'b0 : (match ? 1'b1 : pin);
                end else if (match) begin
                    wave_next = !down;
                end
            end
        endcase
    endfunction : wave_next

    // ======================================================================
    // Register bus.
    reg_wr_t     wr;
    logic [7:0]  rd_addr;
    logic [31:0] rd_word;

    pwm_axi_slave u_bus (
        .clk     (CLK),
        .rst_n   (rst_n),
        .awaddr  (S_AXI_AWADDR),
        .awvalid (S_AXI_AWVALID),
        .awready (S_AXI_AWREADY),
        .wdata   (S_AXI_WDATA),
        .wstrb   (S_AXI_WSTRB),
        .wvalid  (S_AXI_WVALID),
        .wready  (S_AXI_WREADY),
        .bresp   (S_AXI_BRESP),
        .bvalid  (S_AXI_BVALID),
        .bready  (S_AXI_BREADY),
        .araddr  (S_AXI_ARADDR),
        .arvalid (S_AXI_ARVALID),
        .arready (S_AXI_ARREADY),
        .rdata   (S_AXI_RDATA),
        .rresp   (S_AXI_RRESP),
        .rvalid  (S_AXI_RVALID),
        .rready  (S_AXI_RREADY),
        .wr      (wr),
        .rd_addr (rd_addr),
        .rd_word (rd_word)
    );

    // ======================================================================
    // Counter, compare and output state.
    ctrl_t      ctrl_q, ctrl_d;
    logic [7:0] cmpa_buf_q, cmpa_buf_d, cmpb_buf_q, cmpb_buf_d;
    logic [7:0] cmpa_act_q, cmpa_act_d, cmpb_act_q, cmpb_act_d;
    logic [7:0] cnt_q, cnt_d;
    dir_t       dir_q, dir_d;
    logic       ovf_q, ovf_d;
    logic       pin_a_q, pin_a_d, pin_b_q, pin_b_d;
    logic       ovr_a_q, ovr_a_d, ovr_b_q, ovr_b_d;

    logic       fast, dual, pwm, tick;
    logic [7:0] top;
    logic       at_top, at_bot, down_eff, ovf_evt, load_evt;
    logic       match_a, match_b, cnt_wr;

    always_comb begin
        fast     = is_fast(ctrl_q.mode); // RULE1
        dual     = is_dual(ctrl_q.mode); // RULE12
        pwm      = fast || dual;
        tick     = TIMER_TICK && pwm;
        top      = ctrl_q.mode[2] ? cmpa_act_q : `TOP_FIXED; // RULE2 RULE13
        at_top   = cnt_q >= top;
        at_bot   = cnt_q == `BOTTOM;
        down_eff = ((dir_q == DIR_DOWN) && !at_bot) || at_top;
        match_a  = cnt_q == cmpa_act_q;
        match_b  = cnt_q == cmpb_act_q;
        ovf_evt  = tick && ((fast && at_top) || // RULE6
                   (dual && at_bot && (dir_q == DIR_DOWN))); // RULE16
        load_evt = tick && at_top; // RULE21
        cnt_wr   = wr.en && (wr.addr == `REG_COUNT_ADDR);
    end

    always_comb begin
        ctrl_d     = ctrl_q;
        cmpa_buf_d = cmpa_buf_q;
        cmpb_buf_d = cmpb_buf_q;
        cmpa_act_d = cmpa_act_q;
        cmpb_act_d = cmpb_act_q;
        cnt_d      = cnt_q;
        dir_d      = dir_q;
        ovf_d      = ovf_q;
        pin_a_d    = pin_a_q;
        pin_b_d    = pin_b_q;
        if (tick) begin
            if (fast) begin
                cnt_d = at_top ? `BOTTOM : 8'(cnt_q + 8'h01); // RULE3 RULE10
                dir_d = DIR_UP;
            end else if (at_top) begin
                dir_d = DIR_DOWN; // RULE14
                cnt_d = at_bot ? `BOTTOM : 8'(cnt_q - 8'h01);
            end else if (at_bot) begin
                dir_d = DIR_UP; // RULE17
                cnt_d = 8'(cnt_q + 8'h01);
            end else if (dir_q == DIR_UP) begin
                cnt_d = 8'(cnt_q + 8'h01);
            end else begin
                cnt_d = 8'(cnt_q - 8'h01);
            end
            pin_a_d = wave_next(pin_a_q, ctrl_q.sel_a, ctrl_q.mode[2], fast,
                                match_a, at_top, down_eff); // RULE4 RULE5 RULE15
            pin_b_d = wave_next(pin_b_q, ctrl_q.sel_b, 1'b0, fast,
                                match_b, at_top, down_eff); // RULE7 RULE9 RULE18
        end
        if (load_evt) begin
            cmpa_act_d = cmpa_buf_q; // RULE11
            cmpb_act_d = cmpb_buf_q;
        end
        if (wr.en) begin
            unique case (wr.addr)
                `REG_CTRL_ADDR: begin
                    ctrl_d      = wr.data;
                    ctrl_d.rsvd = 1'b0;
                end
                `REG_CMPA_ADDR: begin
                    cmpa_buf_d = wr.data;
                end
                `REG_CMPB_ADDR: begin
                    cmpb_buf_d = wr.data;
                end
                `REG_COUNT_ADDR: begin
                    cnt_d = wr.data;
                end
                `REG_STATUS_ADDR: begin
                    if (wr.data[`STATUS_OVF_BIT]) begin
                        ovf_d = 1'b0;
                    end
                end
                default: begin
                    ctrl_d = ctrl_q;
                end
            endcase
        end
        if (!pwm) begin
            cmpa_act_d = cmpa_buf_d;
            cmpb_act_d = cmpb_buf_d;
        end
        if (ovf_evt) begin
            ovf_d = 1'b1;
        end
        ovr_a_d = drives(ctrl_d.sel_a, ctrl_d.mode[2]); // RULE7 RULE8 RULE19
        ovr_b_d = drives(ctrl_d.sel_b, 1'b0); // RULE19
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q     <= `CTRL_RESET;
            cmpa_buf_q <= `CMP_RESET;
            cmpb_buf_q <= `CMP_RESET;
            cmpa_act_q <= `CMP_RESET;
            cmpb_act_q <= `CMP_RESET;
            cnt_q      <= `BOTTOM;
            dir_q      <= DIR_UP;
            ovf_q      <= 1'b0;
            pin_a_q    <= 1'b0;
            pin_b_q    <= 1'b0;
            ovr_a_q    <= 1'b0;
            ovr_b_q    <= 1'b0;
        end else begin
            ctrl_q     <= ctrl_d;
            cmpa_buf_q <= cmpa_buf_d;
            cmpb_buf_q <= cmpb_buf_d;
            cmpa_act_q <= cmpa_act_d;
            cmpb_act_q <= cmpb_act_d;
            cnt_q      <= cnt_d;
            dir_q      <= dir_d;
            ovf_q      <= ovf_d;
            pin_a_q    <= pin_a_d;
            pin_b_q    <= pin_b_d;
            ovr_a_q    <= ovr_a_d;
            ovr_b_q    <= ovr_b_d;
        end
    end

    always_comb begin
        rd_word = 32'h00000000;
        unique case (rd_addr)
            `REG_CTRL_ADDR:   rd_word[7:0] = ctrl_q;
            `REG_CMPA_ADDR:   rd_word[7:0] = cmpa_buf_q;
            `REG_CMPB_ADDR:   rd_word[7:0] = cmpb_buf_q;
            `REG_COUNT_ADDR:  rd_word[7:0] = cnt_q;
            `REG_STATUS_ADDR: rd_word[3:0] = {pin_b_q, pin_a_q, dir_q, ovf_q};
            default:          rd_word = 32'h00000000;
        endcase
    end

    assign OUT_A     = pin_a_q;
    assign OUT_A_OVR = ovr_a_q;
    assign OUT_B     = pin_b_q;
    assign OUT_B_OVR = ovr_b_q;
    assign OVF_FLAG  = ovf_q;

    // ======================================================================
    // Checks.
    logic [9:0] per_cnt_q, per_cnt_d;
    logic       per_ok_q, per_ok_d;

    always_comb begin
        per_cnt_d = per_cnt_q;
        per_ok_d  = per_ok_q;
        if (ovf_evt) begin
            per_cnt_d = 10'h000;
            per_ok_d  = 1'b1;
        end else if (tick) begin
            per_cnt_d = 10'(per_cnt_q + 10'h001);
        end
        if (wr.en) begin
            per_ok_d = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            per_cnt_q <= 10'h000;
            per_ok_q  <= 1'b0;
        end else begin
            per_cnt_q <= per_cnt_d;
            per_ok_q  <= per_ok_d;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);

    a_fast_wrap: assert property (tick && fast && at_top && !wr.en |=> cnt_q == `BOTTOM) // RULE3
        else $error("single-slope counter did not clear after top");
    a_fast_step: assert property (tick && fast && !at_top && !wr.en
                                  |=> cnt_q == 8'($past(cnt_q) + 8'h01)) // RULE1
        else $error("single-slope counter did not step up");
    a_dual_turn: assert property (tick && dual && at_top && !at_bot && !wr.en
                                  |=> dir_q == DIR_DOWN && cnt_q < $past(cnt_q)) // RULE14
        else $error("dual-slope counter did not turn at top");
    a_ovf_fast: assert property (ovf_evt && fast |=> ovf_q) // RULE6
        else $error("overflow flag missed at top");
    a_ovf_dual: assert property (tick && dual && at_bot && dir_q == DIR_DOWN |=> ovf_q) // RULE16
        else $error("overflow flag missed at bottom");
    a_fast_period: assert property (ovf_evt && per_ok_q && ctrl_q.mode == `MODE_FAST_FIXED
                                    |-> 10'(per_cnt_q + 10'h001) == `FAST_PERIOD) // RULE10
        else $error("single-slope period is not 256 ticks");
    a_dual_period: assert property (ovf_evt && per_ok_q && ctrl_q.mode == `MODE_PC_FIXED
                                    |-> 10'(per_cnt_q + 10'h001) == `DUAL_PERIOD) // RULE17
        else $error("dual-slope period is not 510 ticks");
    a_noninv_clr: assert property (tick && fast && ctrl_q.sel_a == `SEL_NONINV && match_a
                                   && !at_top |=> !OUT_A) // RULE4
        else $error("non-inverting output not cleared on match");
    a_inv_clr: assert property (tick && fast && ctrl_q.sel_a == `SEL_INV && at_top
                                |=> !OUT_A) // RULE5
        else $error("inverting output not cleared at bottom");
    a_dual_match: assert property (tick && dual && ctrl_q.sel_a == `SEL_NONINV && match_a
                                   |=> OUT_A == $past(down_eff)) // RULE15
        else $error("dual-slope match gave the wrong level");
    a_b_no_toggle: assert property (ctrl_q.sel_b == `SEL_TOGGLE |-> !OUT_B_OVR) // RULE7
        else $error("channel B took the toggle selection");
    a_dbuf_hold: assert property (pwm && !load_evt && !wr.en |=> $stable(cmpa_act_q)) // RULE11
        else $error("active compare changed away from top");

    c_fast_wrap: cover property (tick && fast && at_top);
    c_dual_bottom: cover property (tick && dual && at_bot && dir_q == DIR_DOWN);
    c_toggle_a: cover property (tick && ctrl_q.sel_a == `SEL_TOGGLE && ctrl_q.mode[2] && match_a);
    c_ovf_clear: cover property (ovf_q ##1 !ovf_q);

endmodule : eight_bit_pwm_waveform_unit
`default_nettype wire

// ===== verilog/pwm_axi_slave.sv
// AXI4-Lite slave that turns bus transfers into register writes and reads.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_regs.svh"

module pwm_axi_slave
    import pwm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output reg_wr_t          wr,
    output logic [7:0]       rd_addr,
    input  wire logic [31:0] rd_word
);

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[1:0] == 2'h0) && (a <= `REG_STATUS_ADDR);
    endfunction : addr_ok

    logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [7:0]  aw_addr_q, aw_addr_d;
    logic [7:0]  w_data_q,  w_data_d;
    logic        w_strb_q,  w_strb_d;
    logic        awready_q, awready_d, wready_q, wready_d;
    logic        bvalid_q,  bvalid_d;
    logic [1:0]  bresp_q,   bresp_d, rresp_q, rresp_d;
    logic        arready_q, arready_d, rvalid_q, rvalid_d;
    logic [31:0] rdata_q,   rdata_d;

    assign rd_addr = araddr;

    always_comb begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d  = w_have_q;
        w_data_d  = w_data_q;
        w_strb_d  = w_strb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        wr        = '0;
        if (awvalid && awready_q) begin
            aw_have_d = 1'b1;
            aw_addr_d = awaddr;
        end
        if (wvalid && wready_q) begin
            w_have_d = 1'b1;
            w_data_d = wdata[7:0];
            w_strb_d = wstrb[0];
        end
        if (bvalid_q && bready) begin
            bvalid_d = 1'b0;
        end
        if (aw_have_q && w_have_q && !bvalid_q) begin
            wr.en     = w_strb_q && addr_ok(aw_addr_q);
            wr.addr   = aw_addr_q;
            wr.data   = w_data_q;
            bvalid_d  = 1'b1;
            bresp_d   = addr_ok(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d  = !w_have_d && !bvalid_d;
        arready_d = arready_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        if (arvalid && arready_q) begin
            arready_d = 1'b0;
            rvalid_d  = 1'b1;
            rdata_d   = addr_ok(araddr) ? rd_word : 32'h00000000;
            rresp_d   = addr_ok(araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid_q && rready) begin
            rvalid_d  = 1'b0;
            arready_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_have_q  <= 1'b0;
            w_data_q  <= 8'h00;
            w_strb_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h00000000;
            rresp_q   <= 2'h0;
        end else begin
            aw_have_q <= aw_have_d;
            aw_addr_q <= aw_addr_d;
            w_have_q  <= w_have_d;
            w_data_q  <= w_data_d;
            w_strb_q  <= w_strb_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    assign awready = awready_q;
    assign wready  = wready_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign arready = arready_q;
    assign rvalid  = rvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;

endmodule : pwm_axi_slave
`default_nettype wire
